// >>> rtl/sdl_pkg.sv
package sdl_pkg;
  // Character framing
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned CHAR_BITS      = 10;
  localparam int unsigned STOP_IDX       = 9;
  // Sync character 80H holds eight low bit times
  localparam int unsigned SYNC_LOW_BITS  = 8;
  localparam int unsigned SYNC_SHIFT     = 3;
  // Break sizes in bit times, and the sent break in characters
  localparam int unsigned BREAK_BITS     = 9;
  localparam int unsigned BREAK_TX_CHARS = 4;
  localparam int unsigned BREAK_TX_BITS  = BREAK_TX_CHARS * CHAR_BITS;
  localparam int unsigned IDX_W          = 6;
  // Slowest bit rate is the system clock divided by this
  localparam int unsigned MIN_BAUD_DIV   = 512;
  // Runtime counter
  localparam int unsigned RUN_W          = 16;
  localparam logic [15:0] RUN_ZERO       = 16'h0000;
  localparam logic [15:0] RUN_MAX        = 16'hffff;
  // Register map, 8-bit data
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_RXDATA = 3'h2;
  localparam logic [2:0] ADDR_TXDATA = 3'h3;
  localparam logic [2:0] ADDR_RUN_LO = 3'h4;
  localparam logic [2:0] ADDR_RUN_HI = 3'h5;
  localparam int unsigned CTRL_DBG_BIT   = 7;
  localparam int unsigned CTRL_BRKEN_BIT = 6;
  localparam int unsigned STS_LOCK_BIT   = 0;
  localparam int unsigned STS_RXFULL_BIT = 1;
  localparam int unsigned STS_BUSY_BIT   = 2;
  localparam int unsigned STS_BRK_BIT    = 3;
  localparam int unsigned STS_FRM_BIT    = 4;
  localparam int unsigned STS_COL_BIT    = 5;
  localparam int unsigned STS_DBG_BIT    = 6;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  // Link sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_RX      = 3'b001,
    ST_TX      = 3'b010,
    ST_BREAK   = 3'b011,
    ST_WAIT_HI = 3'b100
  } sdl_link_e;
endpackage

// >>> rtl/sdl_baud.sv
module sdl_baud #(
  parameter int unsigned MAX_BIT_DIV = sdl_pkg::MIN_BAUD_DIV,
  parameter int unsigned BIT_W       = $clog2(MAX_BIT_DIV + 1),
  parameter int unsigned CNT_W       = $clog2(sdl_pkg::BREAK_BITS
                                              * MAX_BIT_DIV + 1)
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_line,
  output logic                  o_locked,
  output logic [BIT_W-1:0]      o_bit_cycles
);
  localparam logic [CNT_W-1:0] SYNC_MAX =
    CNT_W'(sdl_pkg::SYNC_LOW_BITS * MAX_BIT_DIV);
  localparam logic [BIT_W-1:0] BIT_ONE = BIT_W'(1);

  logic             meas_q, meas_d, lock_q, lock_d, prev_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [BIT_W-1:0] bit_q, bit_d, bit_raw;

  // Time the low stretch of the sync character, bit time is one eighth
  always_comb
  begin
    meas_d  = meas_q;
    lock_d  = lock_q;
    cnt_d   = cnt_q;
    bit_d   = bit_q;
    bit_raw = BIT_W'(cnt_q >> sdl_pkg::SYNC_SHIFT);
    if (i_clear)
    begin
      meas_d = 1'b0;
      lock_d = 1'b0;
      cnt_d  = '0;
    end
    else if (!lock_q)
    begin
      if (!meas_q && prev_q && !i_line)
      begin
        meas_d = 1'b1;
        cnt_d  = CNT_W'(1);
      end
      else if (meas_q && !i_line)
        cnt_d = cnt_q + CNT_W'(cnt_q != '1);
      else if (meas_q)
      begin
        meas_d = 1'b0;
        // Too long for a sync: a break, so keep waiting
        lock_d = (cnt_q <= SYNC_MAX);
        bit_d  = (bit_raw == '0) ? BIT_ONE : bit_raw;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      meas_q <= 1'b0;
      lock_q <= 1'b0;
      cnt_q  <= '0;
      bit_q  <= BIT_ONE;
      prev_q <= 1'b0; // Line low through reset is no sync edge
    end
    else
    begin
      meas_q <= meas_d;
      lock_q <= lock_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      prev_q <= i_line;
    end
  end

  assign o_locked     = lock_q;
  assign o_bit_cycles = bit_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_bit_stable;
    lock_q && !i_clear |=> $stable(bit_q) && (bit_q <= BIT_W'(MAX_BIT_DIV));
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("bit time changed while locked");
endmodule

// >>> rtl/sdl_runtime.sv
module sdl_runtime #(
  parameter int unsigned W = sdl_pkg::RUN_W
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic          i_debug_mode,
  output logic [W-1:0]       o_count
);
  logic         run_q, run_d, prev_q;
  logic [W-1:0] cnt_q, cnt_d;

  // Restart from zero on leaving debug mode, freeze on entry or at top
  always_comb
  begin
    run_d = run_q;
    cnt_d = cnt_q;
    if (prev_q && !i_debug_mode)
    begin
      run_d = 1'b1;
      cnt_d = W'(sdl_pkg::RUN_ZERO);
    end
    else if (i_debug_mode || cnt_q == W'(sdl_pkg::RUN_MAX))
      run_d = 1'b0;
    else if (run_q)
      cnt_d = cnt_q + W'(1);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      run_q  <= 1'b0;
      cnt_q  <= W'(sdl_pkg::RUN_ZERO);
      prev_q <= 1'b0;
    end
    else
    begin
      run_q  <= run_d;
      cnt_q  <= cnt_d;
      prev_q <= i_debug_mode;
    end
  end

  assign o_count = cnt_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_no_wrap;
    cnt_q == W'(sdl_pkg::RUN_MAX) && !(prev_q && !i_debug_mode)
      |=> cnt_q == W'(sdl_pkg::RUN_MAX);
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("runtime counter wrapped");

  property p_stop_in_debug;
    i_debug_mode && prev_q |=> $stable(cnt_q);
  endproperty
  a_stop_in_debug: assert property (p_stop_in_debug)
    else $error("runtime counter moved in debug mode");
endmodule

// >>> rtl/sdl_top.sv
// Behaviour
// - One open-drain line, half duplex: send and receive never overlap.
// - Character: low start, eight data bits LSB first, high stop.
// - After reset nothing is sent until the host has sent data.
// - Time the eight low bits of 80H, set the bit generator.
// - Bit rates down to clock divided by 512 are supported.
// - Nine low bit times reset autobaud; host resends 80H.
// - Flag received break, low stop bit and transmit collision.
// - On error drop the character, send four-character break, reset baud.
// - Host break resets only autobaud, control and debug mode kept.
// - Unit stays in reset until the line returns high.
// - Debug mode halts fetch; clock and peripherals keep running.
// - Entering debug mode ends halt; watchdog refreshed while in it.
// - Enter on break opcode, or if line low in last reset cycle.
// - Leave on control bit written 0, or on any system reset.
// - Line low during stop mode requests a system reset.
// - Break opcode enters debug mode if enabled, else is a no-op.
// - 16-bit cycle counter runs outside debug mode, stops at FFFFH; from reset it holds 0000H until the first debug exit.
// - Counter starts each interval at 0000H and never wraps.
//
// Chosen here: the address-and-strobe port and the register offsets.
module sdl_top #(
  parameter int unsigned MAX_BIT_DIV = sdl_pkg::MIN_BAUD_DIV
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_line_in,
  output logic             o_line_out,
  output logic             o_line_oe,
  input  wire logic        i_brk_decode,
  input  wire logic        i_stop_mode,
  input  wire logic        i_wdt_enable,
  output logic             o_debug_mode,
  output logic             o_fetch_halt,
  output logic             o_halt_exit,
  output logic             o_wdt_refresh,
  output logic             o_sys_reset_req,
  input  wire logic [2:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [7:0]       o_reg_rdata
);
  localparam int unsigned BIT_W = $clog2(MAX_BIT_DIV + 1);
  localparam int unsigned CNT_W = $clog2(sdl_pkg::BREAK_BITS
                                         * MAX_BIT_DIV + 1);
  localparam int unsigned IW    = sdl_pkg::IDX_W;

  sdl_pkg::sdl_link_e st_q, st_d;
  logic [BIT_W-1:0]  tmr_q, tmr_d, bit_cyc, bit_m1, bit_half;
  logic [IW-1:0]     idx_q, idx_d;
  logic [CNT_W-1:0]  low_q, low_d, brk_lim;
  logic [7:0]        rsh_q, rsh_d, rxd_q, rxd_d;
  logic [9:0]        tsh_q, tsh_d;
  logic              oe_q, oe_d, exp1_q, exp2_q;
  logic              line_m_q, line_s_q, line_p_q, strap_q;
  logic              baud_lock, baud_clear, tick, fall, col, tx_go;
  logic              rx_new, e_brk, e_frm, e_col;
  logic              dbg_q, dbg_d, brken_q, brken_d, rel_q;
  logic              hexit_q, hexit_d, rreq_q;
  logic              rxf_q, rxf_d, sbrk_q, sbrk_d, sfrm_q, sfrm_d;
  logic              scol_q, scol_d;
  logic [7:0]        rdata_q, rdata_d;
  logic [15:0]       run_cnt;

  // Two-flop synchroniser, and the level caught during reset
  always_ff @(posedge i_clock)
  begin
    line_m_q <= i_line_in;
    line_s_q <= line_m_q;
    line_p_q <= line_s_q;
    if (!i_rst_n)
      strap_q <= !line_s_q;
  end

  // Held clear from the end of our break until the host lets go
  assign baud_clear = (st_q == sdl_pkg::ST_WAIT_HI);

  sdl_baud #(
    .MAX_BIT_DIV (MAX_BIT_DIV),
    .BIT_W       (BIT_W),
    .CNT_W       (CNT_W)
  ) u_baud (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_clear      (baud_clear),
    .i_line       (line_s_q),
    .o_locked     (baud_lock),
    .o_bit_cycles (bit_cyc)
  );

  sdl_runtime #(
    .W (sdl_pkg::RUN_W)
  ) u_run (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_debug_mode (dbg_q),
    .o_count      (run_cnt)
  );

  // Bit timing derived from the measured bit time
  assign bit_m1   = bit_cyc - BIT_W'(1);
  assign bit_half = bit_cyc >> 1;
  assign brk_lim  = CNT_W'(bit_cyc * sdl_pkg::BREAK_BITS);
  assign tick     = (tmr_q == '0);
  assign fall     = line_p_q && !line_s_q;
  // Line seen low two cycles after we released it: someone else drives
  assign col      = exp2_q && !line_s_q;
  // Nothing goes out before the host has sent its sync
  assign tx_go    = i_reg_wr && i_reg_addr == sdl_pkg::ADDR_TXDATA
                    && baud_lock && !fall;

  // Link sequencer: one state for receive and send keeps it half duplex
  always_comb
  begin
    st_d   = st_q;
    idx_d  = idx_q;
    rsh_d  = rsh_q;
    tsh_d  = tsh_q;
    rxd_d  = rxd_q;
    rx_new = 1'b0;
    e_brk  = 1'b0;
    e_frm  = 1'b0;
    e_col  = 1'b0;
    tmr_d  = tick ? bit_m1 : tmr_q - BIT_W'(1);
    low_d  = line_s_q ? '0 : low_q + CNT_W'(low_q != '1);
    case (st_q)
      sdl_pkg::ST_IDLE:
      begin
        if (baud_lock && fall)
        begin
          st_d  = sdl_pkg::ST_RX;
          tmr_d = bit_half;
          idx_d = '0;
        end
        else if (tx_go)
        begin
          st_d  = sdl_pkg::ST_TX;
          tsh_d = {1'b1, i_reg_wdata, 1'b0};
          tmr_d = bit_m1;
          idx_d = '0;
        end
      end
      sdl_pkg::ST_RX:
      begin
        if (low_q >= brk_lim)
          e_brk = 1'b1;
        else if (tick)
        begin
          idx_d = idx_q + IW'(1);
          if (idx_q == '0 && line_s_q)
            st_d = sdl_pkg::ST_IDLE;
          else if (idx_q == IW'(sdl_pkg::STOP_IDX))
          begin
            st_d = sdl_pkg::ST_IDLE;
            if (line_s_q)
            begin
              rx_new = 1'b1;
              rxd_d  = rsh_q;
            end
            else
              e_frm = 1'b1;
          end
          else if (idx_q != '0)
            rsh_d = {line_s_q, rsh_q[7:1]};
        end
      end
      sdl_pkg::ST_TX:
      begin
        if (col)
          e_col = 1'b1;
        else if (tick)
        begin
          tsh_d = {1'b1, tsh_q[9:1]};
          idx_d = idx_q + IW'(1);
          if (idx_q == IW'(sdl_pkg::STOP_IDX))
            st_d = sdl_pkg::ST_IDLE;
        end
      end
      sdl_pkg::ST_BREAK:
      begin
        if (tick)
        begin
          idx_d = idx_q + IW'(1);
          if (idx_q == IW'(sdl_pkg::BREAK_TX_BITS - 1))
            st_d = sdl_pkg::ST_WAIT_HI;
        end
      end
      sdl_pkg::ST_WAIT_HI:
      begin
        if (line_s_q)
          st_d = sdl_pkg::ST_IDLE;
      end
      default:
        st_d = sdl_pkg::ST_IDLE;
    endcase
    // Any error drops the character and answers with a long break
    if (e_brk || e_frm || e_col)
    begin
      st_d  = sdl_pkg::ST_BREAK;
      idx_d = '0;
      tmr_d = bit_m1;
    end
    oe_d = (st_d == sdl_pkg::ST_BREAK)
           || (st_d == sdl_pkg::ST_TX && !tsh_d[0]);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      st_q   <= sdl_pkg::ST_IDLE;
      tmr_q  <= '0;
      idx_q  <= '0;
      low_q  <= '0;
      rsh_q  <= sdl_pkg::BYTE_ZERO;
      rxd_q  <= sdl_pkg::BYTE_ZERO;
      tsh_q  <= '1;
      oe_q   <= 1'b0;
      exp1_q <= 1'b0;
      exp2_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      idx_q  <= idx_d;
      low_q  <= low_d;
      rsh_q  <= rsh_d;
      rxd_q  <= rxd_d;
      tsh_q  <= tsh_d;
      oe_q   <= oe_d;
      exp1_q <= !oe_q && st_q == sdl_pkg::ST_TX;
      exp2_q <= exp1_q && st_q == sdl_pkg::ST_TX;
    end
  end

  // Control, flags and read data; hardware set wins over software clear
  always_comb
  begin
    dbg_d   = dbg_q;
    brken_d = brken_q;
    rxf_d   = rxf_q;
    sbrk_d  = sbrk_q;
    sfrm_d  = sfrm_q;
    scol_d  = scol_q;
    rdata_d = sdl_pkg::BYTE_ZERO;
    if (i_reg_wr && i_reg_addr == sdl_pkg::ADDR_CTRL)
    begin
      dbg_d   = i_reg_wdata[sdl_pkg::CTRL_DBG_BIT];
      brken_d = i_reg_wdata[sdl_pkg::CTRL_BRKEN_BIT];
    end
    if (i_brk_decode && brken_q)
      dbg_d = 1'b1;
    if (!rel_q)
      dbg_d = strap_q;
    if (i_reg_wr && i_reg_addr == sdl_pkg::ADDR_STATUS)
    begin
      sbrk_d = sbrk_q && !i_reg_wdata[sdl_pkg::STS_BRK_BIT];
      sfrm_d = sfrm_q && !i_reg_wdata[sdl_pkg::STS_FRM_BIT];
      scol_d = scol_q && !i_reg_wdata[sdl_pkg::STS_COL_BIT];
    end
    if (i_reg_rd && i_reg_addr == sdl_pkg::ADDR_RXDATA)
      rxf_d = 1'b0;
    rxf_d  = rxf_d || rx_new;
    sbrk_d = sbrk_d || e_brk;
    sfrm_d = sfrm_d || e_frm;
    scol_d = scol_d || e_col;
    hexit_d = dbg_d && !dbg_q;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        sdl_pkg::ADDR_CTRL:
        begin
          rdata_d[sdl_pkg::CTRL_DBG_BIT]   = dbg_q;
          rdata_d[sdl_pkg::CTRL_BRKEN_BIT] = brken_q;
        end
        sdl_pkg::ADDR_STATUS:
        begin
          rdata_d[sdl_pkg::STS_LOCK_BIT]   = baud_lock;
          rdata_d[sdl_pkg::STS_RXFULL_BIT] = rxf_q;
          rdata_d[sdl_pkg::STS_BUSY_BIT]   = (st_q != sdl_pkg::ST_IDLE);
          rdata_d[sdl_pkg::STS_BRK_BIT]    = sbrk_q;
          rdata_d[sdl_pkg::STS_FRM_BIT]    = sfrm_q;
          rdata_d[sdl_pkg::STS_COL_BIT]    = scol_q;
          rdata_d[sdl_pkg::STS_DBG_BIT]    = dbg_q;
        end
        sdl_pkg::ADDR_RXDATA: rdata_d = rxd_q;
        sdl_pkg::ADDR_RUN_LO: rdata_d = run_cnt[7:0];
        sdl_pkg::ADDR_RUN_HI: rdata_d = run_cnt[15:8];
        default:              rdata_d = sdl_pkg::BYTE_ZERO;
      endcase
    end
  end

  // System reset of any source clears debug mode and the control bits
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      dbg_q   <= 1'b0;
      brken_q <= 1'b0;
      rel_q   <= 1'b0;
      hexit_q <= 1'b0;
      rreq_q  <= 1'b0;
      rxf_q   <= 1'b0;
      sbrk_q  <= 1'b0;
      sfrm_q  <= 1'b0;
      scol_q  <= 1'b0;
      rdata_q <= sdl_pkg::BYTE_ZERO;
    end
    else
    begin
      dbg_q   <= dbg_d;
      brken_q <= brken_d;
      rel_q   <= 1'b1;
      hexit_q <= hexit_d;
      rreq_q  <= i_stop_mode && !line_s_q;
      rxf_q   <= rxf_d;
      sbrk_q  <= sbrk_d;
      sfrm_q  <= sfrm_d;
      scol_q  <= scol_d;
      rdata_q <= rdata_d;
    end
  end

  // Open drain: only ever pull low
  assign o_line_out      = 1'b0;
  assign o_line_oe       = oe_q;
  assign o_debug_mode    = dbg_q;
  assign o_fetch_halt    = dbg_q;
  assign o_wdt_refresh   = dbg_q && i_wdt_enable;
  assign o_halt_exit     = hexit_q;
  assign o_sys_reset_req = rreq_q;
  assign o_reg_rdata     = rdata_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_silent;
    !baud_lock && st_q != sdl_pkg::ST_BREAK |-> !o_line_oe;
  endproperty
  a_silent: assert property (p_silent)
    else $error("line driven before sync");

  property p_err_break;
    $past(st_q == sdl_pkg::ST_RX || st_q == sdl_pkg::ST_TX)
      && $rose(sbrk_q || sfrm_q || scol_q) |-> o_line_oe;
  endproperty
  a_err_break: assert property (p_err_break)
    else $error("error not answered by break");

  property p_hold;
    st_q == sdl_pkg::ST_WAIT_HI && !line_s_q
      |=> st_q == sdl_pkg::ST_WAIT_HI && !o_line_oe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("left reset hold while line low");

  property p_keep_mode;
    st_q == sdl_pkg::ST_WAIT_HI && !i_reg_wr && !i_brk_decode
      |=> $stable(dbg_q);
  endproperty
  a_keep_mode: assert property (p_keep_mode)
    else $error("host break changed debug mode");

  property p_bp_enter;
    i_brk_decode && brken_q && rel_q |=> o_debug_mode;
  endproperty
  a_bp_enter: assert property (p_bp_enter)
    else $error("break opcode did not enter debug mode");

  property p_bp_nop;
    i_brk_decode && !brken_q && !dbg_q && rel_q && !i_reg_wr
      |=> !o_debug_mode;
  endproperty
  a_bp_nop: assert property (p_bp_nop)
    else $error("disabled break opcode entered debug mode");

  property p_halt_exit;
    $rose(o_debug_mode) |-> o_halt_exit ##1 !o_halt_exit;
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("halt exit pulse wrong");

  property p_stop_reset;
    i_stop_mode && !line_s_q |=> o_sys_reset_req;
  endproperty
  a_stop_reset: assert property (p_stop_reset)
    else $error("no reset request from stop mode");

  property p_break_len;
    st_q == sdl_pkg::ST_BREAK |-> o_line_oe && idx_q
      < IW'(sdl_pkg::BREAK_TX_BITS);
  endproperty
  a_break_len: assert property (p_break_len)
    else $error("break too long or released");

  property p_collide;
    st_q == sdl_pkg::ST_TX && col |=> scol_q && o_line_oe;
  endproperty
  a_collide: assert property (p_collide)
    else $error("collision not flagged");

  c_lock: cover property ($rose(baud_lock));
  c_rx: cover property (rx_new);
  c_tx_done: cover property (st_q == sdl_pkg::ST_TX
                             ##1 st_q == sdl_pkg::ST_IDLE);
  c_break: cover property (st_q == sdl_pkg::ST_BREAK
                           ##1 st_q == sdl_pkg::ST_WAIT_HI);
endmodule

// >>> verif/sdl_host_model.sv
module sdl_host_model #(
  parameter int unsigned BIT_CYC = 8 // Clock over 8
) (
  input  wire logic i_clock,
  input  wire logic i_line,
  output logic      o_pull_low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_pull_low = 1'b0;

  // Hold the line at one level from the next edge
  task automatic set_low(input logic v);
    @(posedge i_clock);
    o_pull_low <= v;
  endtask

  // Low start, data LSB first, high stop; 80H first
  task automatic send_char(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge i_clock);
      o_pull_low <= ~f[i];
      repeat (BIT_CYC - 1) @(posedge i_clock);
    end
  endtask

  // Long low, sent even over device traffic
  task automatic send_break(input int n);
    @(posedge i_clock);
    o_pull_low <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_pull_low <= 1'b0;
  endtask

  // Listen only, never drive: half duplex
  task automatic recv_char(output logic [7:0] b);
    int w;
    w = 0;
    while (i_line && w < 20 * BIT_CYC)
    begin
      @(posedge i_clock);
      w++;
    end
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = i_line;
      repeat (BIT_CYC) @(posedge i_clock);
    end
  endtask
endmodule

// >>> verif/sdl_top_tb_top.sv
module sdl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int B = 8;
  logic       i_clock, i_rst_n, break_opcode, stp, wdt, wr, rd;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, lo;
  logic       oe, dbg, fh, hx, wref, rreq, host_low, lout;
  wire        line;
  int         err_total, comparisons, n;
  logic [15:0] rows [3] = '{16'h5a5a, 16'ha5a5, 16'h0101};

  // Open drain with pull-up: low if anyone pulls
  assign line = ~((oe & ~lout) | host_low);

  sdl_top DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_line_in(line),
    .o_line_out(lout), .o_line_oe(oe), .i_brk_decode(break_opcode),
    .i_stop_mode(stp), .i_wdt_enable(wdt), .o_debug_mode(dbg),
    .o_fetch_halt(fh), .o_halt_exit(hx), .o_wdt_refresh(wref),
    .o_sys_reset_req(rreq), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));

  sdl_host_model #(.BIT_CYC(B)) host (.i_clock(i_clock), .i_line(line),
    .o_pull_low(host_low));

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Register bus, one-cycle strobes
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    rd <= 1'b1; addr <= a;
    @(posedge i_clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // CPU decode of a 00H the host wrote over code
  task automatic pulse_brk;
    @(posedge i_clock);
    break_opcode <= 1'b1;
    @(posedge i_clock);
    break_opcode <= 1'b0;
  endtask

  // Reset with the line held at a chosen level
  task automatic do_reset(input logic low);
    host.set_low(low);
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    host.set_low(1'b0);
    #1 check(dbg, low);
  endtask

  // Exit debug, run c cycles, stop on break opcode
  task automatic run_for(input int c, output logic [15:0] cnt);
    wreg(sdl_pkg::ADDR_CTRL, 8'h40);
    #1 check(dbg, 1'b0);
    repeat (c) @(posedge i_clock);
    pulse_brk();
    rreg(sdl_pkg::ADDR_RUN_LO, lo);
    rreg(sdl_pkg::ADDR_RUN_HI, v);
    cnt = {v, lo};
  endtask

  // Run time bound
  initial
  begin
    repeat (95000) @(posedge i_clock);
    err_total++;
    conclude();
  end

  initial
  begin
    logic [15:0] cnt;
    {i_rst_n, break_opcode, stp, wr, rd, addr, wdata} = '0;
    wdt = 1'b1;
    err_total = 0;
    comparisons = 0;
    do_reset(1'b0);
    n = 0;
    repeat (100) @(posedge i_clock) #1 n += oe;
    check(n, 0);
    rreg(sdl_pkg::ADDR_CTRL, v);
    check(v, 8'h00);
    rreg(3'h6, v);
    check(v, 8'h00);
    host.send_char(8'h80);
    repeat (B) @(posedge i_clock);
    rreg(sdl_pkg::ADDR_STATUS, v);
    check(v[0], 1'b1);
    $display("reset and sync done");
    // Each row: byte in from host, byte echoed back out
    foreach (rows[i])
    begin
      host.send_char(rows[i][15:8]);
      repeat (B) @(posedge i_clock);
      rreg(sdl_pkg::ADDR_RXDATA, v);
      check(v, rows[i][7:0]);
      wreg(sdl_pkg::ADDR_TXDATA, rows[i][7:0]);
      host.recv_char(v);
      check(v, rows[i][7:0]);
      repeat (2 * B) @(posedge i_clock);
    end
    $display("row table done");
    pulse_brk();
    #1 check(dbg, 1'b0);
    wreg(sdl_pkg::ADDR_CTRL, 8'h40);
    pulse_brk();
    // Halt exit rises with debug mode and stands one cycle
    #1 n = hx;
    repeat (3) @(posedge i_clock) #1 n += hx;
    check(n, 1);
    check({dbg, fh, wref}, 3'b111);
    @(posedge i_clock) wdt <= 1'b0;
    #1 check(wref, 1'b0);
    @(posedge i_clock) wdt <= 1'b1;
    $display("breakpoint done");
    run_for(200, cnt);
    check((cnt >= 200) && (cnt <= 210), 1'b1);
    run_for(66000, cnt);
    check(cnt, 16'hffff);
    $display("runtime done");
    // Host break while in debug mode: only the link resets
    n = 0;
    fork
      host.send_break(12 * B);
      repeat (700) @(posedge i_clock) #1 n += oe;
    join
    check(n, 40 * B);
    rreg(sdl_pkg::ADDR_STATUS, v);
    check(v & 8'h49, 8'h48);
    host.send_char(8'h80);
    repeat (B) @(posedge i_clock);
    rreg(sdl_pkg::ADDR_STATUS, v);
    check(v[0], 1'b1);
    $display("host break done");
    // Host break over our own character is a collision
    wreg(sdl_pkg::ADDR_TXDATA, 8'hff);
    host.send_break(12 * B);
    repeat (400) @(posedge i_clock);
    rreg(sdl_pkg::ADDR_STATUS, v);
    check(v & 8'h25, 8'h20);
    wreg(sdl_pkg::ADDR_STATUS, 8'h38);
    rreg(sdl_pkg::ADDR_STATUS, v);
    check(v & 8'h38, 8'h00);
    $display("collision done");
    host.set_low(1'b1);
    repeat (4) @(posedge i_clock);
    #1 check(rreq, 1'b0);
    @(posedge i_clock) stp <= 1'b1;
    repeat (4) @(posedge i_clock);
    #1 check(rreq, 1'b1);
    @(posedge i_clock) stp <= 1'b0;
    host.set_low(1'b0);
    $display("stop mode done");
    do_reset(1'b1);
    // A line held low through reset is not a sync start
    repeat (4) @(posedge i_clock);
    rreg(sdl_pkg::ADDR_STATUS, v);
    check(v & 8'h41, 8'h40);
    do_reset(1'b0);
    $display("strap done");
    conclude();
  end
endmodule
